// ### tb/pptpwm_host.sv
// Host model: makes the pulse train at a fixed 40-cycle period.
// Assumes the bench moves high_cycles only while the train is low.
`timescale 1ns/1ps
`default_nettype none
module pptpwm_host (
  input  wire logic       sys_clk,
  input  wire logic       current_limit_flag,
  input  wire logic       run,
  input  wire logic [7:0] high_cycles,
  output var  logic       pulse_train_in
);
  logic ready;
  int   cnt;
  initial begin
    ready = 1'h0;
    cnt = 0;
    pulse_train_in = 1'h0;
  end
  // Nothing leaves until the flag is seen low; the period never moves,
  // only the high time, so soft-start keeps the frequency.
  always @(negedge sys_clk) begin
    if (run && !current_limit_flag)
      ready = 1'h1;
    if (!run)
      ready = 1'h0;
    pulse_train_in = ready && cnt < high_cycles;
    cnt = (ready && cnt < 39) ? cnt + 1 : 0;
  end
endmodule : pptpwm_host
`default_nettype wire

// ### tb/pptpwm_monitor.sv
// Checker for the pulse-train PWM logic, bound to its top module.
// Assumes four-edge input synchronisers and registered outputs.
`timescale 1ns/1ps
`default_nettype none
module pptpwm_monitor (
  input wire logic       sys_clk,
  input wire logic       srst,
  input wire logic       pulse_train_in,
  input wire logic       reference_good,
  input wire logic       pwm_comparator_trip,
  input wire logic       limit_threshold_input,
  input wire logic [1:0] ramp_set_resistor_pin,
  input wire logic       drive_output_a,
  input wire logic       drive_output_b,
  input wire logic       current_limit_flag,
  input wire logic       ramp_internal_en,
  input wire logic       ramp_feedforward_en,
  input wire logic       slope_comp_en
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);
  // Six samples outlast the synchroniser, so the cause must have landed.
  wire logic off = !drive_output_a && !drive_output_b;
  ref_low_off_a: assert property (!reference_good[*6] |-> off)
    else $error("drive on while reference low");
  train_low_off_a: assert property (!pulse_train_in[*6] |-> off)
    else $error("drive on while train low");
  limit_cuts_a: assert property (limit_threshold_input[*5] |=> off)
    else $error("drive on during limit trip");
  no_overlap_a: assert property (!(drive_output_a && drive_output_b))
    else $error("both drives on");
  rise_cause_a: assert property ($rose(!off) |->
    $past(pulse_train_in, 4) && $past(reference_good, 4))
    else $error("drive rose without train edge");
  reset_flag_a: assert property ($fell(srst) |-> current_limit_flag)
    else $error("flag low after reset");
  flag_cause_a: assert property ($rose(current_limit_flag) |->
    $past(limit_threshold_input, 5) || !$past(reference_good, 5))
    else $error("flag rose without trip");
  // Eight quiet samples outlast the strap synchroniser and the decode flop.
  mode_decode_a: assert property ((!reference_good &&
    $stable(ramp_set_resistor_pin))[*8] |->
    {ramp_internal_en, ramp_feedforward_en, slope_comp_en} ==
    {ramp_set_resistor_pin == 2'h1,
     ramp_set_resistor_pin == 2'h2,
     ramp_set_resistor_pin == 2'h0})
    else $error("mode outputs differ from strap");
  cover property ($rose(drive_output_b));
  cover property ($rose(current_limit_flag));
  cover property ($fell(current_limit_flag));
endmodule : pptpwm_monitor
////////////////////////////////////////////////////////////////////////////
bind pptpwm_top pptpwm_monitor pptpwm_monitor_inst (.*);
`default_nettype wire

// ### tb/pptpwm_top_tb.sv
// Self-checking bench for the pulse-train PWM logic.
// Assumes the host model and the bound checker; inputs move at negedge.
`timescale 1ns/1ps
`default_nettype none
module pptpwm_top_tb;
  logic       sys_clk, srst, reference_good, pwm_comparator_trip, run;
  logic       limit_threshold_input, pulse_train_in, is_a;
  logic       drive_output_a, drive_output_b, current_limit_flag;
  logic       ramp_internal_en, ramp_feedforward_en, slope_comp_en;
  logic [1:0] ramp_set_resistor_pin;
  logic [7:0] high_cycles, w;
  int         failures, total_checks;
  wire  logic [2:0] mode = {ramp_internal_en, ramp_feedforward_en,
                            slope_comp_en};
  pptpwm_top pptpwm_top_inst (.*);
  pptpwm_host pptpwm_host_inst (.*);
  initial begin
    sys_clk = 1'h0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic end_of_test();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : end_of_test
  // Waits for a drive pulse and counts its length; at sample cut it raises
  // the comparator or limit trip, dropped again once the drive is off.
  task automatic pulse(input int cut, input logic lim);
    int n;
    n = 0;
    w = 8'h0;
    while (!(drive_output_a || drive_output_b) && n < 100) begin
      @(negedge sys_clk);
      n++;
    end
    is_a = drive_output_a;
    while ((drive_output_a || drive_output_b) && w < 8'h60) begin
      w++;
      if (w == cut && lim)
        limit_threshold_input = 1'h1;
      else if (w == cut)
        pwm_comparator_trip = 1'h1;
      @(negedge sys_clk);
    end
    {limit_threshold_input, pwm_comparator_trip} = 2'h0;
  endtask : pulse
  ////////////////////////////////////////////////////////////////////////
  task automatic t_modes();
    logic [2:0] exp [4] = '{3'h1, 3'h4, 3'h2, 3'h0};
    for (int s = 0; s < 4; s++) begin
      ramp_set_resistor_pin = s[1:0];
      repeat (10) @(negedge sys_clk);
      check(mode, exp[s]);
    end
    ramp_set_resistor_pin = 2'h1;
  endtask : t_modes
  task automatic t_start();
    int n;
    run = 1'h1;
    repeat (20) @(negedge sys_clk);
    check(current_limit_flag, 1'h1);
    reference_good = 1'h1;
    for (n = 0; n < 20 && current_limit_flag; n++)
      @(negedge sys_clk);
    check(current_limit_flag, 1'h0);
  endtask : t_start
  // Soft-start: width follows the train's high time, drives alternate.
  task automatic t_soft();
    for (int i = 0; i < 4; i++) begin
      pulse(0, 1'h0);
      check(is_a, i % 2 == 0);
      check(w, high_cycles);
      high_cycles = high_cycles + 8'h4;
    end
  endtask : t_soft
  task automatic t_cut();
    high_cycles = 8'h14;
    pulse(3, 1'h0);
    check(w, 8'h7);
    pulse(3, 1'h1);
    check(w, 8'h7);
    repeat (10) @(negedge sys_clk);
    check(current_limit_flag, 1'h1);
    pulse(0, 1'h0);
    check(current_limit_flag, 1'h0);
    check(w, 8'h14);
  endtask : t_cut
  task automatic t_drop();
    reference_good = 1'h0;
    repeat (8) @(negedge sys_clk);
    repeat (80) begin
      check(drive_output_a | drive_output_b, 1'h0);
      @(negedge sys_clk);
    end
    reference_good = 1'h1;
    pulse(0, 1'h0);
    check(is_a, 1'h1);
  endtask : t_drop
  initial begin
    {srst, run, reference_good, pwm_comparator_trip} = 4'h8;
    limit_threshold_input = 1'h0;
    ramp_set_resistor_pin = 2'h1;
    high_cycles = 8'h6;
    failures = 0;
    total_checks = 0;
    repeat (5) @(negedge sys_clk);
    srst = 1'h0;
    t_modes();
    t_start();
    t_soft();
    t_cut();
    t_drop();
    end_of_test();
  end
  // Watchdog: the tests need about five hundred cycles.
  initial begin
    #(25 * 4000);
    failures++;
    end_of_test();
  end
endmodule : pptpwm_top_tb
`default_nettype wire

// ### verilog/pptpwm_pkg.sv
// Package for the push-pull pulse-train PWM logic.
// Holds the strap mode encoding and reset values shared by the design files.
// Assumes a single 40 MHz system clock.
`default_nettype none

package pptpwm_pkg;

  // Control mode chosen by the ramp-set resistor strap.
  typedef enum logic [1:0] {
    PPTPWM_MODE_VM,      // Plain voltage mode, internal ramp.
    PPTPWM_MODE_VMFF,    // Voltage mode with input feed-forward ramp.
    PPTPWM_MODE_CMC,     // Peak current mode with slope compensation.
    PPTPWM_MODE_NONE     // Strap not yet resolved.
  } pptpwm_mode_e;

  // Strap pin levels as seen on the two-bit sense input.
  localparam logic [1:0] PPTPWM_STRAP_RAIL   = 2'h1;
  localparam logic [1:0] PPTPWM_STRAP_VIN    = 2'h2;
  localparam logic [1:0] PPTPWM_STRAP_GROUND = 2'h0;

  // Values held in reset.
  localparam logic PPTPWM_FLAG_RST   = 1'h1;
  localparam logic PPTPWM_PHASE_RST  = 1'h0;
  localparam logic PPTPWM_SYNC_RST   = 1'h0;

  // Synchroniser length for pin inputs.
  localparam int PPTPWM_SYNC_STAGES = 3;

endpackage : pptpwm_pkg

`default_nettype wire

// ### verilog/pptpwm_sync.sv
// Three-stage synchroniser with agreement filter for one pin input.
// Assumes the pin is asynchronous to sys_clk; output changes once the
// second and third stages agree.
`timescale 1ns/1ps
`default_nettype none

module pptpwm_sync (
  input  wire logic sys_clk,
  input  wire logic srst,
  input  wire logic pin_in,
  output var  logic level_out
);

  logic [2:0] stage_ff;
  logic [2:0] nxt_stage;
  logic       level_ff;
  logic       nxt_level;

  ////////////////////////////////////////////////////////////////////////////
  // Shift the pin in; the first stage feeds only the second.
  always_comb begin
    nxt_stage = {stage_ff[1:0], pin_in};
    nxt_level = level_ff;
    if (stage_ff[1] == stage_ff[2]) begin
      nxt_level = stage_ff[2];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      stage_ff <= {3{pptpwm_pkg::PPTPWM_SYNC_RST}};
      level_ff <= pptpwm_pkg::PPTPWM_SYNC_RST;
    end else begin
      stage_ff <= nxt_stage;
      level_ff <= nxt_level;
    end
  end

  assign level_out = level_ff;

endmodule : pptpwm_sync

`default_nettype wire

// ### verilog/pptpwm_top.sv
// Push-pull PWM control logic driven by a pulse-train input.
// Assumes analog comparators, ramp and gate drivers sit outside; their
// results arrive as pins and are synchronised here.
//
// Contract
// - Each pulse-train rising edge starts a new switching period.
// - While reference-good is low, ignore pulse train, keep drives off.
// - After reference-good rises, process pulse-train edges into pulses.
// - Pulse-train low forces both drives off, capping duty cycle.
// - Current-limit trip turns active drive off and sets the flag; the code sets the flag only while the pulse train is high.
// - Drives alternate; each runs at half the pulse-train frequency.
// - Strap on regulated rail selects plain voltage mode.
// - Strap on input supply selects voltage mode with feed-forward.
// - Strap on analog ground selects peak current mode with slope.
// - Current-limit flag stays latched until next pulse-train rising edge.
// - Flag is held high at start-up until supplies are good.
`timescale 1ns/1ps
`default_nettype none

module pptpwm_top (
  input  wire logic       sys_clk,
  input  wire logic       srst,
  input  wire logic       pulse_train_in,
  input  wire logic       reference_good,
  input  wire logic       pwm_comparator_trip,
  input  wire logic       limit_threshold_input,
  input  wire logic [1:0] ramp_set_resistor_pin,
  output var  logic       drive_output_a,
  output var  logic       drive_output_b,
  output var  logic       current_limit_flag,
  output var  logic       ramp_internal_en,
  output var  logic       ramp_feedforward_en,
  output var  logic       slope_comp_en
);

  logic                   clk_lvl;
  logic                   ref_lvl;
  logic                   cmp_lvl;
  logic                   lim_lvl;
  logic                   strap_lo_lvl;
  logic                   strap_hi_lvl;
  logic                   clk_prev_ff;
  logic                   nxt_clk_prev;
  logic                   phase_ff;
  logic                   nxt_phase;
  logic                   on_ff;
  logic                   nxt_on;
  logic                   drv_a_ff;
  logic                   nxt_drv_a;
  logic                   drv_b_ff;
  logic                   nxt_drv_b;
  logic                   flag_ff;
  logic                   nxt_flag;
  logic                   ref_seen_ff;
  logic                   nxt_ref_seen;
  pptpwm_pkg::pptpwm_mode_e mode_ff;
  pptpwm_pkg::pptpwm_mode_e nxt_mode;
  logic                   vm_ff;
  logic                   nxt_vm;
  logic                   ff_ff;
  logic                   nxt_ff;
  logic                   cmc_ff;
  logic                   nxt_cmc;
  logic                   rise;
  logic                   fall;

  ////////////////////////////////////////////////////////////////////////////
  // Every pin from the analog side crosses through its own synchroniser.
  pptpwm_sync u_sync_clk (
    .sys_clk   (sys_clk),
    .srst      (srst),
    .pin_in    (pulse_train_in),
    .level_out (clk_lvl)
  );

  pptpwm_sync u_sync_ref (
    .sys_clk   (sys_clk),
    .srst      (srst),
    .pin_in    (reference_good),
    .level_out (ref_lvl)
  );

  pptpwm_sync u_sync_cmp (
    .sys_clk   (sys_clk),
    .srst      (srst),
    .pin_in    (pwm_comparator_trip),
    .level_out (cmp_lvl)
  );

  pptpwm_sync u_sync_lim (
    .sys_clk   (sys_clk),
    .srst      (srst),
    .pin_in    (limit_threshold_input),
    .level_out (lim_lvl)
  );

  // The strap bits cross one by one. A strap moved while the part is held
  // off may show a mixed code for a cycle; the decode settles once both
  // bits agree, and the mode is frozen only after reference-good rises.
  pptpwm_sync u_sync_strap_lo (
    .sys_clk   (sys_clk),
    .srst      (srst),
    .pin_in    (ramp_set_resistor_pin[0]),
    .level_out (strap_lo_lvl)
  );

  pptpwm_sync u_sync_strap_hi (
    .sys_clk   (sys_clk),
    .srst      (srst),
    .pin_in    (ramp_set_resistor_pin[1]),
    .level_out (strap_hi_lvl)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Edge detection on the filtered pulse train.
  assign rise = clk_lvl & ~clk_prev_ff;
  assign fall = ~clk_lvl & clk_prev_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Pulse steering. A rising edge opens a period on the phase's output and
  // flips the phase; edges seen before reference-good are dropped, so the
  // first rising edge after start-up always selects drive A.
  always_comb begin
    nxt_clk_prev = clk_lvl;
    nxt_phase    = phase_ff;
    nxt_on       = on_ff;
    nxt_ref_seen = ref_seen_ff | ref_lvl;
    if (!ref_lvl) begin
      nxt_on    = 1'b0;
      nxt_phase = pptpwm_pkg::PPTPWM_PHASE_RST;
    end else if (rise) begin
      nxt_on    = 1'b1;
      nxt_phase = ~phase_ff;
    end else if (fall || !clk_lvl || cmp_lvl || lim_lvl) begin
      nxt_on    = 1'b0;
    end
    // Termination also masks the rising-edge cycle so a limit held high
    // across the edge never produces even a one-cycle sliver.
    if (rise && (cmp_lvl || lim_lvl)) begin
      nxt_on = 1'b0;
    end
    // The phase flips at the rising edge, so the reset phase leads to A.
    nxt_drv_a = nxt_on & nxt_phase;
    nxt_drv_b = nxt_on & ~nxt_phase;
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      clk_prev_ff <= pptpwm_pkg::PPTPWM_SYNC_RST;
      phase_ff    <= pptpwm_pkg::PPTPWM_PHASE_RST;
      on_ff       <= 1'b0;
      drv_a_ff    <= 1'b0;
      drv_b_ff    <= 1'b0;
      ref_seen_ff <= 1'b0;
    end else begin
      clk_prev_ff <= nxt_clk_prev;
      phase_ff    <= nxt_phase;
      on_ff       <= nxt_on;
      drv_a_ff    <= nxt_drv_a;
      drv_b_ff    <= nxt_drv_b;
      ref_seen_ff <= nxt_ref_seen;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Current-limit flag. High from reset until reference-good, then set by a
  // limit trip while the pulse train is high, cleared only by the next rising edge.
  // A trip in the same cycle as a rising edge wins, so no event is lost.
  always_comb begin
    nxt_flag = flag_ff;
    if (!ref_lvl) begin
      nxt_flag = 1'b1;
    end else if (lim_lvl && clk_lvl) begin
      nxt_flag = 1'b1;
    end else if (rise || !ref_seen_ff) begin
      nxt_flag = 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      flag_ff <= pptpwm_pkg::PPTPWM_FLAG_RST;
    end else begin
      flag_ff <= nxt_flag;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Strap decode. The strap is sampled while reference-good is low and
  // frozen afterwards, so a glitch on the sense pins cannot swap the ramp
  // in mid-operation.
  always_comb begin
    nxt_mode = mode_ff;
    if (!ref_lvl) begin
      case ({strap_hi_lvl, strap_lo_lvl})
        pptpwm_pkg::PPTPWM_STRAP_RAIL: begin
          nxt_mode = pptpwm_pkg::PPTPWM_MODE_VM;
        end
        pptpwm_pkg::PPTPWM_STRAP_VIN: begin
          nxt_mode = pptpwm_pkg::PPTPWM_MODE_VMFF;
        end
        pptpwm_pkg::PPTPWM_STRAP_GROUND: begin
          nxt_mode = pptpwm_pkg::PPTPWM_MODE_CMC;
        end
        default: begin
          nxt_mode = pptpwm_pkg::PPTPWM_MODE_NONE;
        end
      endcase
    end
    nxt_vm  = (nxt_mode == pptpwm_pkg::PPTPWM_MODE_VM);
    nxt_ff  = (nxt_mode == pptpwm_pkg::PPTPWM_MODE_VMFF);
    nxt_cmc = (nxt_mode == pptpwm_pkg::PPTPWM_MODE_CMC);
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      mode_ff <= pptpwm_pkg::PPTPWM_MODE_NONE;
      vm_ff   <= 1'b0;
      ff_ff   <= 1'b0;
      cmc_ff  <= 1'b0;
    end else begin
      mode_ff <= nxt_mode;
      vm_ff   <= nxt_vm;
      ff_ff   <= nxt_ff;
      cmc_ff  <= nxt_cmc;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs come straight from flip-flops.
  assign drive_output_a      = drv_a_ff;
  assign drive_output_b      = drv_b_ff;
  assign current_limit_flag  = flag_ff;
  assign ramp_internal_en    = vm_ff;
  assign ramp_feedforward_en = ff_ff;
  assign slope_comp_en       = cmc_ff;

endmodule : pptpwm_top

`default_nettype wire
